// ===== logic/pif_pkg.sv
// Package with register map, field layout and carrier types for the request flag block
package pif_pkg;
   localparam logic [9:0]  PIF_FLAGS_IDX   = 10'h00D;  // Request flags, register index
   localparam logic [11:0] PIF_FLAGS_OFF   = {PIF_FLAGS_IDX, 2'b00};  // Byte address of flags
   localparam logic [11:0] PIF_ENABLE_OFF  = 12'h038;  // Enable bits, same layout as flags
   localparam logic [11:0] PIF_CORE_OFF    = 12'h03C;  // Core control and status
   localparam logic [11:0] PIF_CAPCMP_OFF  = 12'h040;  // Unit-2 mode select and compare value
   localparam logic [11:0] PIF_PORT_A_A_OFF   = 12'h044;  // Port A pin levels, read only
   localparam int          PIF_TOUCH_BIT   = 6;
   localparam int          PIF_PORT_A_A_BIT   = 5;
   localparam int          PIF_EEPROM_BIT  = 4;
   localparam int          PIF_CAPCMP_BIT  = 0;
   localparam logic [7:0]  PIF_FLAGS_RST   = 8'h00;
   localparam logic [7:0]  PIF_FLAGS_MASK  = 8'h71;
   localparam int          PIF_CORE_GIE_BIT = 0;
   localparam int          PIF_CORE_ISR_BIT = 1;
   localparam logic [15:0] PIF_VECTOR_ADDR = 16'h0004;
   localparam logic [15:0] PIF_CMP_RST     = 16'h0000;

   typedef enum logic [1:0] {
      PIF_MODE_OFF,
      PIF_MODE_CAPTURE,
      PIF_MODE_COMPARE,
      PIF_MODE_PWM
   } pif_mode_e;

   typedef struct packed {
      logic touch_done;      // Touch sequence complete pulse
      logic eeprom_done;     // Program memory write complete pulse
      logic capture_evt;     // Unit-2 capture edge pulse
   } pif_events_s;

   typedef struct packed {
      logic return_from_interrupt; // Core executed return instruction
      logic take_ack;              // Core has taken the vector
   } pif_core_s;
endpackage : pif_pkg

// ===== logic/pif_apb_slave.sv
// APB slave front end: decode, single-cycle ready and error on unmapped addresses
`timescale 1ns/1ps
module pif_apb_slave #(
   parameter int AW = 12
) (
   input  wire logic          sys_clk_i,   // System clock
   input  wire logic          rst_n_i,     // Async reset, active low
   input  wire logic          psel_i,      // APB select
   input  wire logic          penable_i,   // APB enable
   input  wire logic          pwrite_i,    // APB direction
   input  wire logic [AW-1:0] paddr_i,     // APB address
   input  wire logic          mapped_i,    // Address decodes to a register
   input  wire logic [31:0]   rdata_i,     // Register read mux
   output logic               wr_o,        // Write strobe, access phase
   output logic               rd_o,        // Read strobe, access phase
   output logic               pready_o,    // APB ready
   output logic               pslverr_o,   // APB error
   output logic [31:0]        prdata_o     // APB read data
);
   wire setup_w = psel_i && !penable_i;

   assign wr_o = psel_i && penable_i && pwrite_i && mapped_i && pready_o;
   assign rd_o = psel_i && penable_i && !pwrite_i && mapped_i && pready_o;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h00000000;
      end else begin
         pready_o  <= setup_w;
         pslverr_o <= setup_w && !mapped_i;
         prdata_o  <= (setup_w && !pwrite_i && mapped_i) ? rdata_i : 32'h00000000;
      end
   end
endmodule : pif_apb_slave

// ===== logic/pif_irq_flags.sv
// Peripheral request flags, unit-2 capture/compare flag logic and core vectoring control
`timescale 1ns/1ps

// Functional notes
// - EEPROM write completion sets its flag; it stays until software writes 0.
// - EEPROM flag reads 0 while a write is pending or not started.
// - Any port A pin level change sets its flag until software clears it.
// - Capture mode: a timer-one capture sets the unit-2 flag; software clears.
// - PWM mode never sets the unit-2 flag.
// - Accepted request sends the core to fixed vector 0004H.
// - No automatic context save or restore, no push or pop support.
// - While servicing, no further request is accepted even if pending and enabled.
// - Next request is accepted only after return-from-interrupt executes.
// - All sources equal; no hardware priority among simultaneous requests.
// - Flags set on their condition regardless of enable bits or global enable.
module pif_irq_flags
   import pif_pkg::*;
#(
   parameter int PORT_A_A_W = 8,
   parameter int TMR_W   = 16
) (
   input  wire logic               sys_clk_i,     // System clock, 125 MHz
   input  wire logic               rst_n_i,       // Async reset, active low
   input  wire logic               psel_i,        // APB select
   input  wire logic               penable_i,     // APB enable
   input  wire logic               pwrite_i,      // APB direction
   input  wire logic [11:0]        paddr_i,       // APB byte address
   input  wire logic [31:0]        pwdata_i,      // APB write data
   input  wire logic [3:0]         pstrb_i,       // APB byte strobes
   output logic                    pready_o,      // APB ready
   output logic                    pslverr_o,     // APB error
   output logic [31:0]             prdata_o,      // APB read data
   input  wire pif_pkg::pif_events_s events_i,    // Peripheral event pulses
   input  wire logic [PORT_A_A_W-1:0] port_a_a_i,    // Port A pins, asynchronous
   input  wire logic [TMR_W-1:0]   timer_one_count_i, // Timer-one count
   input  wire pif_pkg::pif_core_s core_i,        // Core handshake
   output logic                    irq_req_o,     // Request to core, level
   output logic [15:0]             vector_addr_o, // Vector address to core
   output logic                    in_service_o   // Service routine active
);
   import pif_pkg::*;

   logic [7:0]         flags_q, flags_d;
   logic [7:0]         enable_q;
   logic               gie_q;
   logic               in_service_q;
   pif_mode_e          mode_q;
   logic [TMR_W-1:0]   cmp_q;
   logic [TMR_W-1:0]   cap_q;
   logic [PORT_A_A_W-1:0] pa_meta_q, pa_sync_q, pa_last_q;
   logic               pa_primed_q;
   logic               irq_q;
   logic [15:0]        vec_q;

   // Byte lane 0 write helper
   function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] wd,
                                        input logic [3:0] st);
      lane0 = st[0] ? wd[7:0] : old;
   endfunction : lane0

   // Bus decode
   wire        hit_flags  = (paddr_i == PIF_FLAGS_OFF);
   wire        hit_enable = (paddr_i == PIF_ENABLE_OFF);
   wire        hit_core   = (paddr_i == PIF_CORE_OFF);
   wire        hit_capcmp = (paddr_i == PIF_CAPCMP_OFF);
   wire        hit_port_a_a  = (paddr_i == PIF_PORT_A_A_OFF);
   wire        mapped     = hit_flags | hit_enable | hit_core | hit_capcmp | hit_port_a_a;
   wire        wr_en;
   wire        rd_en;
   logic [31:0] rdata;

   always_comb begin
      rdata = 32'h00000000;
      if (hit_flags)  rdata[7:0] = flags_q & PIF_FLAGS_MASK;
      if (hit_enable) rdata[7:0] = enable_q & PIF_FLAGS_MASK;
      if (hit_core) begin
         rdata[PIF_CORE_GIE_BIT] = gie_q;
         rdata[PIF_CORE_ISR_BIT] = in_service_q;
      end
      if (hit_capcmp) begin
         rdata[1:0]          = mode_q;
         rdata[16+TMR_W-1:16] = cap_q;
      end
      if (hit_port_a_a)  rdata[PORT_A_A_W-1:0] = pa_sync_q;
   end

   pif_apb_slave #(.AW(12)) u_apb (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .psel_i    (psel_i),
      .penable_i (penable_i),
      .pwrite_i  (pwrite_i),
      .paddr_i   (paddr_i),
      .mapped_i  (mapped),
      .rdata_i   (rdata),
      .wr_o      (wr_en),
      .rd_o      (rd_en),
      .pready_o  (pready_o),
      .pslverr_o (pslverr_o),
      .prdata_o  (prdata_o)
   );

   // Port A synchroniser and change detect
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pa_meta_q   <= '0;
         pa_sync_q   <= '0;
         pa_last_q   <= '0;
         pa_primed_q <= 1'b0;
      end else begin
         pa_meta_q   <= port_a_a_i;
         pa_sync_q   <= pa_meta_q;
         pa_last_q   <= pa_sync_q;
         pa_primed_q <= 1'b1;
      end
   end
   // Masks only the first cycle after reset; a nonzero pin level at reset still sets the flag
   wire pa_change = pa_primed_q && (pa_sync_q != pa_last_q);

   // Unit-2 events, gated by mode
   wire cap_evt = (mode_q == PIF_MODE_CAPTURE) && events_i.capture_evt;
   logic cmp_hit_q;
   wire  cmp_eq  = (mode_q == PIF_MODE_COMPARE) && (timer_one_count_i == cmp_q);
   wire  cmp_evt = cmp_eq && !cmp_hit_q;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cap_q     <= '0;
         cmp_hit_q <= 1'b0;
      end else begin
         if (cap_evt) cap_q <= timer_one_count_i;
         cmp_hit_q <= cmp_eq;
      end
   end

   // Flag update: software write first, then hardware sets win
   wire [7:0] sw_val = lane0(flags_q, pwdata_i, pstrb_i);
   always_comb begin
      flags_d = (wr_en && hit_flags) ? (sw_val & PIF_FLAGS_MASK) : flags_q;
      // Sets ignore enables and global enable
      if (events_i.touch_done)  flags_d[PIF_TOUCH_BIT]  = 1'b1;
      if (pa_change)            flags_d[PIF_PORT_A_A_BIT]  = 1'b1;
      if (events_i.eeprom_done) flags_d[PIF_EEPROM_BIT] = 1'b1;
      if (cap_evt || cmp_evt)   flags_d[PIF_CAPCMP_BIT] = 1'b1;
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) flags_q <= PIF_FLAGS_RST;
      else          flags_q <= flags_d;
   end

   // Control registers
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         enable_q <= 8'h00;
         gie_q    <= 1'b0;
         mode_q   <= PIF_MODE_OFF;
         cmp_q    <= PIF_CMP_RST[TMR_W-1:0];
      end else if (wr_en) begin
         if (hit_enable) enable_q <= lane0(enable_q, pwdata_i, pstrb_i) & PIF_FLAGS_MASK;
         if (hit_core && pstrb_i[0]) gie_q <= pwdata_i[PIF_CORE_GIE_BIT];
         if (hit_capcmp) begin
            if (pstrb_i[0]) mode_q <= pif_mode_e'(pwdata_i[1:0]);
            if (pstrb_i[2]) cmp_q[7:0] <= pwdata_i[23:16];
            if (pstrb_i[3]) cmp_q[TMR_W-1:8] <= pwdata_i[16+TMR_W-1:24];
         end
      end
   end

   // Any enabled flag requests while global enable is set; no source ranking in hardware
   wire pending = gie_q && |(flags_q & enable_q & PIF_FLAGS_MASK);

   // Service state: one routine at a time
   typedef enum logic [1:0] {
      PIF_ST_IDLE,
      PIF_ST_REQ,
      PIF_ST_SERVICE
   } pif_state_e;
   pif_state_e st_q, st_d;

   always_comb begin
      st_d = st_q;
      case (st_q)
         PIF_ST_IDLE:    if (pending) st_d = PIF_ST_REQ;
         PIF_ST_REQ:     if (core_i.take_ack) st_d = PIF_ST_SERVICE;
                         else if (!pending) st_d = PIF_ST_IDLE;
         // Only the return instruction reopens acceptance
         PIF_ST_SERVICE: if (core_i.return_from_interrupt) st_d = PIF_ST_IDLE;
         default:        st_d = PIF_ST_IDLE;
      endcase
   end

   // Vector only; registers of the core are never saved here
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q         <= PIF_ST_IDLE;
         irq_q        <= 1'b0;
         in_service_q <= 1'b0;
         vec_q        <= 16'h0000;
      end else begin
         st_q         <= st_d;
         irq_q        <= (st_d == PIF_ST_REQ);
         in_service_q <= (st_d == PIF_ST_SERVICE);
         vec_q        <= PIF_VECTOR_ADDR;
      end
   end

   assign irq_req_o     = irq_q;
   assign vector_addr_o = vec_q;
   assign in_service_o  = in_service_q;

   wire unused_rd = rd_en;
endmodule : pif_irq_flags

// ===== test/pif_core_model.sv
// Behavioural core that takes the vector, runs a service routine and returns
`timescale 1ns/1ps
module pif_core_model
   import pif_pkg::*;
#(
   parameter int SVC_LEN = 12
) (
   input  wire logic          sys_clk_i,     // System clock
   input  wire logic          rst_n_i,       // Reset, active low
   input  wire logic          irq_req_i,     // Request from block
   input  wire logic [15:0]   vector_addr_i, // Vector from block
   input  wire logic [3:0]    ack_dly_i,     // Cycles before taking
   output pif_pkg::pif_core_s core_o,        // Handshake to block
   output logic [15:0]        pc_o           // Fetch address taken
);
   initial begin
      core_o = '0;
      pc_o = 16'h0000;
      forever begin
         @(posedge sys_clk_i);
         if (rst_n_i && irq_req_i) begin
            repeat (ack_dly_i) @(posedge sys_clk_i);
            if (irq_req_i) begin
               core_o.take_ack <= 1'b1;
               pc_o <= vector_addr_i;
               @(posedge sys_clk_i);
               core_o.take_ack <= 1'b0;
               // Service routine body modelled as SVC_LEN idle cycles, no context save or polling
               repeat (SVC_LEN) @(posedge sys_clk_i);
               core_o.return_from_interrupt <= 1'b1;
               @(posedge sys_clk_i);
               core_o.return_from_interrupt <= 1'b0;
            end
         end
      end
   end
endmodule : pif_core_model

// ===== test/pif_irq_flags_asserts.sv
// Port-level checks of vectoring, nesting and bus answer
`timescale 1ns/1ps
module pif_irq_flags_asserts
   import pif_pkg::*;
(
   input wire logic               sys_clk_i,     // Clock
   input wire logic               rst_n_i,       // Reset
   input wire logic               psel_i,        // Select
   input wire logic               penable_i,     // Enable
   input wire logic               pready_o,      // Ready
   input wire logic               pslverr_o,     // Error
   input wire logic [31:0]        prdata_o,      // Read data
   input wire pif_pkg::pif_core_s core_i,        // Core handshake
   input wire logic               irq_req_o,     // Request
   input wire logic [15:0]        vector_addr_o, // Vector
   input wire logic               in_service_o   // In service
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_vec; $past(rst_n_i) |-> vector_addr_o == PIF_VECTOR_ADDR; endproperty
   a_vec: assert property (p_vec) else $error("vector address wrong");
   property p_ack; irq_req_o && core_i.take_ack |=> in_service_o && !irq_req_o; endproperty
   a_ack: assert property (p_ack) else $error("take not honoured");
   property p_nest; in_service_o |-> !irq_req_o; endproperty
   a_nest: assert property (p_nest) else $error("request during service");
   property p_hold; in_service_o && !core_i.return_from_interrupt |=> in_service_o; endproperty
   a_hold: assert property (p_hold) else $error("service ended early");
   property p_ret; in_service_o && core_i.return_from_interrupt |=> !in_service_o; endproperty
   a_ret: assert property (p_ret) else $error("service not ended");
   property p_rdy; psel_i && !penable_i |=> pready_o; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready after setup");
   property p_one; pready_o |=> !pready_o; endproperty
   a_one: assert property (p_one) else $error("ready too long");
   property p_err; pready_o && pslverr_o |-> prdata_o == 32'h0; endproperty
   a_err: assert property (p_err) else $error("refused read not zero");
endmodule : pif_irq_flags_asserts

bind pif_irq_flags pif_irq_flags_asserts i_pif_irq_flags_asserts (
   .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o), .core_i(core_i),
   .irq_req_o(irq_req_o), .vector_addr_o(vector_addr_o), .in_service_o(in_service_o)
);

// ===== test/pif_irq_flags_tb.sv
// Testbench for request flags and core vectoring
`timescale 1ns/1ps
module pif_irq_flags_tb;
   import pif_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdata;
   logic pready, pslverr, err, irq, insvc;
   logic [7:0] pa = 8'h00;
   logic [15:0] tmr = 16'h0000, vec, pc;
   logic [3:0] ack_dly = 4'h0;
   pif_events_s ev = '0;
   pif_core_s core;
   int error_cnt = 0, check_count = 0, cyc = 0;
   always #4 clk = ~clk;
   pif_irq_flags i_pif_irq_flags (.sys_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .pstrb_i(4'hF), .pready_o(pready), .pslverr_o(pslverr), .prdata_o(prdata),
      .events_i(ev), .port_a_a_i(pa), .timer_one_count_i(tmr), .core_i(core),
      .irq_req_o(irq), .vector_addr_o(vec), .in_service_o(insvc));
   pif_core_model i_pif_core_model (.sys_clk_i(clk), .rst_n_i(rst_n), .irq_req_i(irq),
      .vector_addr_i(vec), .ack_dly_i(ack_dly), .core_o(core), .pc_o(pc));
   task end_sim;
      if (error_cnt == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   task chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rd_chk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdata, e);
   endtask : rd_chk
   task pulse(input pif_events_s e);
      @(posedge clk);
      ev <= e;
      @(posedge clk);
      ev <= '0;
   endtask : pulse
   task wait_svc(input logic l);
      int n;
      n = 0;
      while (insvc !== l && n < 300) begin
         @(posedge clk);
         n++;
      end
      chk({31'h0, insvc}, {31'h0, l});
   endtask : wait_svc
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         end_sim();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(PIF_FLAGS_OFF, 32'h0);
      rd_chk(PIF_ENABLE_OFF, 32'h0);
      apb(1'b0, 12'h100, 32'h0);
      chk({31'h0, err}, 32'h1);
      pulse(3'b110);
      pa <= 8'h01;
      repeat (5) @(posedge clk);
      rd_chk(PIF_FLAGS_OFF, 32'h70);
      rd_chk(PIF_PORT_A_A_OFF, 32'h1);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, PIF_FLAGS_OFF, 32'h0);
      rd_chk(PIF_FLAGS_OFF, 32'h0);
      apb(1'b1, PIF_CAPCMP_OFF, 32'h1);
      tmr <= 16'h1234;
      pulse(3'b001);
      rd_chk(PIF_FLAGS_OFF, 32'h1);
      chk({rdata[31:16], 16'h0}, 32'h0);
      apb(1'b0, PIF_CAPCMP_OFF, 32'h0);
      chk({rdata[31:16], 16'h0}, 32'h12340000);
      apb(1'b1, PIF_FLAGS_OFF, 32'h0);
      apb(1'b1, PIF_CAPCMP_OFF, 32'h3);
      pulse(3'b001);
      rd_chk(PIF_FLAGS_OFF, 32'h0);
      apb(1'b1, PIF_CAPCMP_OFF, 32'h00550002);
      tmr <= 16'h0055;
      rd_chk(PIF_FLAGS_OFF, 32'h1);
      apb(1'b1, PIF_FLAGS_OFF, 32'h0);
      rd_chk(PIF_FLAGS_OFF, 32'h0);
      apb(1'b1, PIF_CAPCMP_OFF, 32'h0);
      apb(1'b1, PIF_ENABLE_OFF, 32'h71);
      apb(1'b1, PIF_CORE_OFF, 32'h1);
      pulse(3'b110);
      wait_svc(1'b1);
      chk({16'h0, pc}, {16'h0, PIF_VECTOR_ADDR});
      rd_chk(PIF_FLAGS_OFF, 32'h50);
      ack_dly <= 4'h5;
      apb(1'b1, PIF_FLAGS_OFF, 32'h10);
      chk({31'h0, irq}, 32'h0);
      wait_svc(1'b0);
      wait_svc(1'b1);
      apb(1'b1, PIF_FLAGS_OFF, 32'h0);
      wait_svc(1'b0);
      repeat (10) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      end_sim();
   end
endmodule : pif_irq_flags_tb
